// ### shared/kdz_pkg.sv
// Constants, register map and state type for the keyed digest and zone lock engine.
package kdz_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [5:0] REG_CMD        = 6'h00;
  localparam logic [5:0] REG_STAT       = 6'h04;
  localparam logic [5:0] REG_LOCK       = 6'h08;
  localparam logic [5:0] REG_CRC        = 6'h0c;
  localparam logic [5:0] REG_RESP       = 6'h10;
  localparam logic [5:0] REG_RESP_LAST  = 6'h2c;
  // Status register field positions.
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_DONE      = 1;
  localparam int         STAT_VALID     = 2;
  localparam int         STAT_ORIGIN    = 3;
  // Command opcodes.
  localparam logic [7:0] OP_HMAC        = 8'h11;
  localparam logic [7:0] OP_LOCK        = 8'h17;
  // Mode and zone fields of the first parameter byte.
  localparam logic [7:0] MODE_RSV_MASK  = 8'h8b;
  localparam int         MODE_ORIGIN    = 2;
  localparam int         MODE_OTP88     = 4;
  localparam int         MODE_OTP64     = 5;
  localparam int         MODE_SN        = 6;
  localparam logic [7:0] ZONE_RSV_MASK  = 8'h7e;
  localparam int         ZONE_DATA      = 0;
  localparam int         ZONE_FORCE     = 7;
  // Lock byte values and status codes.
  localparam logic [7:0] LOCKED         = 8'hff;
  localparam logic [7:0] UNLOCKED       = 8'h55;
  localparam logic [7:0] STS_OK         = 8'h00;
  localparam logic [7:0] STS_PARSE      = 8'h03;
  localparam logic [7:0] STS_EXEC       = 8'h0f;
  // Zone and CRC constants.
  localparam int         CFG_BYTES      = 88;
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  // HMAC and SHA-256 padding constants.
  localparam logic [7:0] IPAD           = 8'h36;
  localparam logic [7:0] OPAD           = 8'h5c;
  localparam logic [7:0] PAD_BYTE       = 8'h80;
  localparam int         PAD1_ZERO_BITS = 248;
  localparam int         PAD2_ZERO_BITS = 184;
  localparam logic [63:0] INNER_LEN     = 64'h4c0;
  localparam logic [63:0] OUTER_LEN     = 64'h300;
  localparam logic [2:0] STEP_MSG0      = 3'h1;
  localparam logic [2:0] STEP_MSG1      = 3'h2;
  localparam logic [2:0] STEP_OKEY      = 3'h3;
  localparam logic [2:0] STEP_LAST      = 3'h4;
  // AXI responses.
  localparam logic [1:0] AXI_OKAY       = 2'b00;
  localparam logic [1:0] AXI_SLVERR     = 2'b10;

  typedef enum logic [2:0] {ST_IDLE, ST_SHA_GO, ST_SHA_WAIT, ST_CRC, ST_FINISH} kdz_state_t;
endpackage : kdz_pkg

// ### hdl/kdz_cmd_exec.sv
// Keyed digest and zone lock command engine with its AXI4-Lite register slave.
// What this block does
// - Keyed digest opcode 0x11: mode, two-byte selector, no data, 32-byte answer.
// - Key slot from selector bits 0:3; all 16 selector bits are hashed.
// - The selected slot's key is the HMAC key.
// - Message: zeros, scratch digest, opcode, mode, selector, OTP 8+3, serial bytes.
// - Standard HMAC over SHA-256 with inner, outer digests and padding.
// - Mode bit 2 must match origin flag; bits 7, 3, 1, 0 stay zero.
// - Mode bit 6 includes serial bytes 2-7, otherwise zeros.
// - Mode bit 5 with bit 4 clear includes OTP bytes 0-7.
// - Mode bit 4 includes OTP bytes 0-10 and overrides bit 5.
// - Serial bytes 8, 0 and 1 are never zeroed.
// - Successful lock sets config or data lock byte to 0xFF.
// - Lock of an already locked zone returns an error.
// - Lock first computes CRC-16 of the zone like the packet CRC.
// - Configuration summary covers all 88 configuration bytes.
// - Data lock CRC runs over data zone then OTP zone.
// - Summary mismatch gives an error and leaves the zone unlocked.
// - Lock opcode 0x17; zone bit 0 picks zone; bits 1-6 zero.
// - Zone bit 7 skips the CRC check and locks anyway.
// - Successful lock answers one status byte of zero.
// - Scratch load marks valid; origin flag random, or input in pass-through.
// - Any executed command clears the scratch valid bit unless a scratch load coincides with its start.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module kdz_cmd_exec
  import kdz_pkg::*;
#(
  parameter int DATA_BYTES = 512,
  parameter int OTP_BYTES  = 64,
  parameter int ZA_W       = $clog2((DATA_BYTES + OTP_BYTES > CFG_BYTES ?
                                     DATA_BYTES + OTP_BYTES : CFG_BYTES) + 1)
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [5:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [5:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         scratchLoad,
  input  wire logic [255:0] scratchLoadData,
  input  wire logic         scratchPassThru,
  output logic [3:0]        keySlot,
  input  wire logic [255:0] keySlotData,
  input  wire logic [87:0]  otpBytes,
  input  wire logic [71:0]  serialNum,
  output logic              zoneSel,
  output logic [ZA_W-1:0]   zoneAddr,
  output logic              zoneRd,
  input  wire logic [7:0]   zoneByte,
  output logic              shaStart,
  output logic              shaFromIv,
  output logic [511:0]      shaBlock,
  input  wire logic         shaDone,
  input  wire logic [255:0] shaDigest,
  output logic [7:0]        configLockByte,
  output logic [7:0]        dataLockByte,
  output logic              busy
);

  localparam logic [ZA_W-1:0] CFG_LEN  = ZA_W'(CFG_BYTES);
  localparam logic [ZA_W-1:0] DATA_LEN = ZA_W'(DATA_BYTES + OTP_BYTES);

  kdz_state_t    state_q;
  logic [7:0]    cmdOp_q, cmdMode_q, status_q, errCode_q, cfgLock_q, dataLock_q;
  logic [15:0]   cmdParam2_q, crc_q;
  logic          go_q, done_q, err_q, scratchValid_q, origin_q, bvalid_q, rvalid_q;
  logic          feed_q, shaStart_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;
  logic [255:0]  scratch_q, innerHash_q, digest_q;
  logic [511:0]  shaBlock_q;
  logic [2:0]    step_q;
  logic [ZA_W-1:0] addrCnt_q;

  // One CRC-16 byte step, LSB of each byte first, same as the packet CRC.
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (b[i] ^ r[15]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcByte

  // Puts byte 0 of an 11-byte field first in hash order.
  function automatic logic [87:0] otpOrder(input logic [87:0] v);
    logic [87:0] r;
    r = '0;
    for (int i = 0; i < 11; i++) begin
      r[87-8*i -: 8] = v[8*i +: 8];
    end
    return r;
  endfunction : otpOrder

  // Bus handshakes: write address and data are taken together in one edge.
  wire wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire rdTake = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Address decode; anything past the last digest word is unmapped.
  wire wrMapped = (s_axi_awaddr[1:0] == 2'b00) && (s_axi_awaddr <= REG_RESP_LAST);
  wire rdMapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= REG_RESP_LAST);
  wire idle     = (state_q == ST_IDLE) && !go_q;
  wire cmdWrite = wrTake && (s_axi_awaddr == REG_CMD) && idle;
  wire [2:0] respIdx = 3'((s_axi_araddr - REG_RESP) >> 2);
  wire [31:0] statWord = {16'h0000, status_q, 4'h0, origin_q, scratchValid_q, done_q, busy};
  wire [31:0] rdWord =
    (s_axi_araddr == REG_CMD)  ? {cmdParam2_q, cmdMode_q, cmdOp_q} :
    (s_axi_araddr == REG_STAT) ? statWord :
    (s_axi_araddr == REG_LOCK) ? {16'h0000, dataLock_q, cfgLock_q} :
    (s_axi_araddr == REG_CRC)  ? {16'h0000, crc_q} :
    (rdMapped)                 ? digest_q[255 - 32*respIdx -: 32] : 32'h0000_0000;

  // Write response and read data channels.
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= AXI_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= AXI_OKAY;
      rdata_q  <= '0;
    end else begin
      if (wrTake) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrMapped ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rdTake) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rdMapped ? AXI_OKAY : AXI_SLVERR;
        rdata_q  <= rdWord;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Command register; a write while busy is acknowledged but dropped.
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdOp_q     <= '0;
      cmdMode_q   <= '0;
      cmdParam2_q <= '0;
      go_q        <= 1'b0;
    end else begin
      go_q <= cmdWrite;
      if (cmdWrite && s_axi_wstrb[0]) cmdOp_q <= s_axi_wdata[7:0];
      if (cmdWrite && s_axi_wstrb[1]) cmdMode_q <= s_axi_wdata[15:8];
      if (cmdWrite && s_axi_wstrb[2]) cmdParam2_q[7:0] <= s_axi_wdata[23:16];
      if (cmdWrite && s_axi_wstrb[3]) cmdParam2_q[15:8] <= s_axi_wdata[31:24];
    end
  end

  // Command decode and checks, evaluated in the cycle of the go pulse.
  wire isHmac    = (cmdOp_q == OP_HMAC);
  wire isLock    = (cmdOp_q == OP_LOCK);
  wire zoneData  = cmdMode_q[ZONE_DATA];
  wire zoneForce = cmdMode_q[ZONE_FORCE];
  wire zoneIsLocked = zoneData ? (dataLock_q == LOCKED) : (cfgLock_q == LOCKED);
  wire [ZA_W-1:0] zoneLen = zoneData ? DATA_LEN : CFG_LEN;
  wire crcMatch  = (crc_q == cmdParam2_q);
  wire lockPass  = isLock && !err_q && (zoneForce || crcMatch);

  assign keySlot = cmdParam2_q[3:0];

  // Serial masking; bytes 8, 0 and 1 always pass, the rest follow mode bit 6.
  wire snEn  = cmdMode_q[MODE_SN];
  wire [71:0] snM = serialNum & {8'hff, {48{snEn}}, 16'hffff};
  wire [71:0] snSeq = {snM[71:64], snM[39:32], snM[47:40], snM[55:48], snM[63:56],
                       snM[7:0], snM[15:8], snM[23:16], snM[31:24]};
  // Mode bit 4 takes all 11 OTP bytes.
  wire otpHi = cmdMode_q[MODE_OTP88];
  // Mode bit 5 alone takes the first 8 OTP bytes.
  wire otpLo = cmdMode_q[MODE_OTP64] | otpHi;
  wire [87:0] otpSeq = otpOrder(otpBytes & {{24{otpHi}}, {64{otpLo}}});

  // Message tail in hash order, selector low byte first as on the wire.
  wire [191:0] msgTail = {cmdOp_q, cmdMode_q, cmdParam2_q[7:0], cmdParam2_q[15:8],
                          otpSeq, snSeq};
  // Slot key padded to a full block as HMAC key.
  wire [511:0] keyBlk  = {keySlotData, 256'h0};
  // Inner then outer hash; five compressions, padding and lengths included.
  wire [511:0] blkMux =
    (step_q == '0)        ? keyBlk ^ {64{IPAD}} :
    (step_q == STEP_MSG0) ? {256'h0, scratch_q} :
    (step_q == STEP_MSG1) ? {msgTail, PAD_BYTE, {PAD1_ZERO_BITS{1'b0}}, INNER_LEN} :
    (step_q == STEP_OKEY) ? keyBlk ^ {64{OPAD}} :
                            {innerHash_q, PAD_BYTE, {PAD2_ZERO_BITS{1'b0}}, OUTER_LEN};

  assign shaStart  = shaStart_q;
  assign shaBlock  = shaBlock_q;
  assign shaFromIv = (step_q == '0) || (step_q == STEP_OKEY);
  assign zoneSel   = zoneData;
  assign zoneAddr  = addrCnt_q;
  assign zoneRd    = (state_q == ST_CRC) && (addrCnt_q < zoneLen);
  assign busy      = !idle;
  assign configLockByte = cfgLock_q;
  assign dataLockByte   = dataLock_q;

  // Sequencer: checks on the go pulse, then either hashing or the zone CRC.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= ST_IDLE;
      err_q      <= 1'b0;
      errCode_q  <= STS_OK;
      step_q     <= '0;
      shaStart_q <= 1'b0;
      shaBlock_q <= '0;
    end else begin
      shaStart_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          err_q  <= 1'b0;
          step_q <= '0;
          if (go_q) state_q <= ST_FINISH; // Branches below override this target.
          if (go_q && isHmac) begin
            // Reserved mode bits and origin flag check.
            if ((cmdMode_q & MODE_RSV_MASK) != 8'h00) begin
              {err_q, errCode_q} <= {1'b1, STS_PARSE};
            // No valid scratch digest is an error.
            end else if (!scratchValid_q) begin
              {err_q, errCode_q} <= {1'b1, STS_EXEC};
            end else if (cmdMode_q[MODE_ORIGIN] != origin_q) begin
              {err_q, errCode_q} <= {1'b1, STS_EXEC};
            end else begin
              state_q <= ST_SHA_GO;
            end
          end else if (go_q && isLock) begin
            // Zone reserved bits must be zero.
            if ((cmdMode_q & ZONE_RSV_MASK) != 8'h00) begin
              {err_q, errCode_q} <= {1'b1, STS_PARSE};
            end else if (zoneIsLocked) begin
              {err_q, errCode_q} <= {1'b1, STS_EXEC};
            // Forced lock skips the CRC pass.
            end else if (zoneForce) begin
              state_q <= ST_FINISH;
            end else begin
              state_q <= ST_CRC;
            end
          end else if (go_q) begin
            {err_q, errCode_q} <= {1'b1, STS_PARSE};
          end
        end
        ST_SHA_GO: begin
          shaBlock_q <= blkMux;
          shaStart_q <= 1'b1;
          state_q    <= ST_SHA_WAIT;
        end
        ST_SHA_WAIT: begin
          if (shaDone && !shaStart_q) begin
            step_q  <= step_q + 3'h1;
            state_q <= (step_q == STEP_LAST) ? ST_FINISH : ST_SHA_GO;
          end
        end
        ST_CRC: begin
          if (!zoneRd && !feed_q) state_q <= ST_FINISH;
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Hash results: inner digest after the message, answer after the outer block.
  always_ff @(posedge clk) begin
    if (srst) begin
      innerHash_q <= '0;
      digest_q    <= '0;
    end else if (state_q == ST_SHA_WAIT && shaDone && !shaStart_q) begin
      if (step_q == STEP_MSG1) innerHash_q <= shaDigest;
      // The 32-byte answer is the outer digest.
      if (step_q == STEP_LAST) digest_q <= shaDigest;
    end
  end

  // Zone CRC with one-cycle read latency on zoneByte.
  // Data pass walks data zone then OTP zone, contiguous.
  always_ff @(posedge clk) begin
    if (srst) begin
      addrCnt_q <= '0;
      feed_q    <= 1'b0;
      crc_q     <= CRC_INIT;
    end else begin
      feed_q <= zoneRd;
      if (go_q) begin
        addrCnt_q <= '0;
        crc_q     <= CRC_INIT;
      end else begin
        if (zoneRd) addrCnt_q <= addrCnt_q + ZA_W'(1);
        if (feed_q) crc_q <= crcByte(crc_q, zoneByte);
      end
    end
  end

  // Completion: status byte, done flag and lock bytes.
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q   <= STS_OK;
      done_q     <= 1'b0;
      cfgLock_q  <= UNLOCKED;
      dataLock_q <= UNLOCKED;
    end else if (go_q) begin
      done_q <= 1'b0;
    end else if (state_q == ST_FINISH) begin
      done_q <= 1'b1;
      // Mismatch reports an error and leaves the zone unlocked.
      status_q <= err_q ? errCode_q : (isLock && !lockPass) ? STS_EXEC : STS_OK;
      // Lock byte of the chosen zone goes to 0xFF.
      if (lockPass && !zoneData) cfgLock_q <= LOCKED;
      if (lockPass && zoneData) dataLock_q <= LOCKED;
    end
  end

  // Scratch digest; a load in the same cycle as a command start wins over the clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      scratch_q      <= '0;
      scratchValid_q <= 1'b0;
      origin_q       <= 1'b0;
    end else if (scratchLoad) begin
      // Load marks valid; origin is 1 for pass-through input, 0 for random.
      scratch_q      <= scratchLoadData;
      scratchValid_q <= 1'b1;
      origin_q       <= scratchPassThru;
    // Any command consumes the valid bit.
    end else if (go_q) begin
      scratchValid_q <= 1'b0;
    end
  end

  // Checks on the running design.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  lock_sets_ff_a: assert property (state_q == ST_FINISH && lockPass && !zoneData |=>
    cfgLock_q == LOCKED && status_q == STS_OK) else $error("config lock byte not set");
  relock_refused_a: assert property (go_q && isLock && zoneIsLocked &&
    (cmdMode_q & ZONE_RSV_MASK) == 8'h00 |=> ##1 (done_q && status_q == STS_EXEC))
    else $error("locked zone not refused");
  crc_miss_keeps_a: assert property (state_q == ST_FINISH && isLock && !err_q &&
    !zoneForce && !crcMatch |=> $stable(cfgLock_q) && $stable(dataLock_q) && status_q == STS_EXEC)
    else $error("mismatched summary changed lock state");
  force_no_crc_a: assert property (go_q && isLock && zoneForce && !zoneIsLocked &&
    (cmdMode_q & ZONE_RSV_MASK) == 8'h00 |=> !zoneRd [*2]) else $error("forced lock read zone");
  cfg_len_a: assert property (zoneRd && !zoneData |-> addrCnt_q < ZA_W'(CFG_BYTES))
    else $error("config CRC ran past 88 bytes");
  valid_clear_a: assert property (go_q && !scratchLoad |=> !scratchValid_q)
    else $error("scratch valid survived a command");
  no_valid_err_a: assert property (go_q && isHmac && !scratchValid_q &&
    (cmdMode_q & MODE_RSV_MASK) == 8'h00 |=> ##1 (done_q && status_q == STS_EXEC))
    else $error("invalid scratch digest not refused");
  origin_err_a: assert property (go_q && isHmac && scratchValid_q &&
    cmdMode_q[MODE_ORIGIN] != origin_q |=> state_q == ST_FINISH) else $error("origin mismatch ran");
  sn_mask_a: assert property (state_q == ST_SHA_GO && step_q == STEP_MSG1 && !snEn |=>
    shaBlock_q[383:352] == 32'h0 && shaBlock_q[335:320] == 16'h0) else $error("serial not masked");
  origin_load_a: assert property (scratchLoad |=> scratchValid_q &&
    origin_q == $past(scratchPassThru)) else $error("scratch load flags wrong");

  hmac_done_c: cover property (state_q == ST_SHA_WAIT && step_q == STEP_LAST && shaDone);
  lock_cfg_c:  cover property (state_q == ST_FINISH && lockPass && !zoneData);
  lock_data_c: cover property (state_q == ST_FINISH && lockPass && zoneData);
  crc_miss_c:  cover property (state_q == ST_FINISH && isLock && !err_q && !lockPass);
endmodule : kdz_cmd_exec

// ### sim/kdz_far_model.sv
// Far-side model: key slots, zone memory and a stand-in compression core.
`timescale 1ns/1ps
module kdz_far_model #(
  parameter int ZA_W = 4
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic [3:0]      keySlot,
  output logic      [255:0]    keySlotData,
  input  wire logic            zoneSel,
  input  wire logic [ZA_W-1:0] zoneAddr,
  input  wire logic            zoneRd,
  output logic      [7:0]      zoneByte,
  input  wire logic            shaStart,
  input  wire logic [511:0]    shaBlock,
  output logic                 shaDone,
  output logic      [255:0]    shaDigest
);
  logic [511:0] blk;
  logic [2:0]   cnt;
  // Zone pattern; the two zones differ so a wrong zone select shows in the CRC.
  function automatic logic [7:0] zb(input logic s, input logic [7:0] a);
    return (a * 8'h1d) ^ (s ? 8'h5a : 8'h07);
  endfunction : zb
  assign keySlotData = {32{keySlot, 4'hc}};
  always_ff @(posedge clk) begin
    if (srst) zoneByte <= 8'h00;
    else zoneByte <= zoneRd ? zb(zoneSel, 8'(zoneAddr)) : ~zoneByte;
  end
  // Not a real compression: the digest folds the block, enough to trace data paths.
  // Delay depends on the block so answers come both promptly and slowly.
  always_ff @(posedge clk) begin
    shaDone <= 1'b0;
    if (srst) begin
      cnt       <= 3'h0;
      shaDigest <= 256'h0;
    end else if (shaStart) begin
      blk <= shaBlock;
      cnt <= shaBlock[0] ? 3'h1 : 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        shaDone   <= 1'b1;
        shaDigest <= blk[511:256] ^ blk[255:0];
      end
    end else shaDigest <= ~shaDigest;
  end
endmodule : kdz_far_model

// ### sim/kdz_cmd_exec_bench.sv
// Self-checking bench for the keyed digest and zone lock engine.
`timescale 1ns/1ps
module kdz_cmd_exec_bench
  import kdz_pkg::*;
;
  localparam int ZW = $clog2(CFG_BYTES + 1);
  logic clk = 1'b0, srst = 1'b1, scratchLoad = 1'b0, scratchPassThru = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, keySlot;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [255:0] scratchLoadData = 256'h0, keySlotData, shaDigest;
  logic [87:0] otpBytes = 88'h0;
  logic [71:0] serialNum = 72'h0;
  logic zoneSel, zoneRd, shaStart, shaFromIv, shaDone, busy;
  logic [ZW-1:0] zoneAddr;
  logic [7:0] zoneByte, configLockByte, dataLockByte;
  logic [511:0] shaBlock;
  logic [33:0] expQ[$];
  logic [512:0] blkQ[$];
  logic [15:0] cc, cd;
  int fails = 0, checked = 0;
  kdz_cmd_exec #(.DATA_BYTES(8), .OTP_BYTES(4)) dut (
    .clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .scratchLoad(scratchLoad), .scratchLoadData(scratchLoadData),
    .scratchPassThru(scratchPassThru), .keySlot(keySlot), .keySlotData(keySlotData),
    .otpBytes(otpBytes), .serialNum(serialNum), .zoneSel(zoneSel), .zoneAddr(zoneAddr),
    .zoneRd(zoneRd), .zoneByte(zoneByte), .shaStart(shaStart), .shaFromIv(shaFromIv),
    .shaBlock(shaBlock), .shaDone(shaDone), .shaDigest(shaDigest),
    .configLockByte(configLockByte), .dataLockByte(dataLockByte), .busy(busy));
  kdz_far_model #(.ZA_W(ZW)) u_far (
    .clk(clk), .srst(srst), .keySlot(keySlot), .keySlotData(keySlotData), .zoneSel(zoneSel),
    .zoneAddr(zoneAddr), .zoneRd(zoneRd), .zoneByte(zoneByte), .shaStart(shaStart),
    .shaBlock(shaBlock), .shaDone(shaDone), .shaDigest(shaDigest));
  always #12.5 clk = ~clk;
  task automatic close_out();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [512:0] s, input logic [512:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp=%0h seen=%0h", n, e, s);
    end
  endtask : chk
  // Read results are compared in arrival order against the driver's notes.
  always @(negedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk("rd", {s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    // Every write here targets the command register, so each answer must be OKAY.
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", s_axi_bresp, AXI_OKAY);
    if (shaStart === 1'b1) blkQ.push_back({shaFromIv, shaBlock});
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    // Start on a rising edge so that back-to-back calls never drive a signal twice at once.
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge clk); while (s_axi_awready !== 1'b1);
    @(posedge clk);
    s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    expQ.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [255:0] dg(input logic [512:0] b);
    return b[511:256] ^ b[255:0];
  endfunction : dg
  // Message tail in hash order; masked fields become zero bytes.
  function automatic logic [191:0] tail(input logic [7:0] m, input logic [15:0] s);
    logic [87:0] o;
    logic [71:0] n;
    for (int k = 0; k < 11; k++)
      o[87-8*k -: 8] = (m[4] || (m[5] && k < 8)) ? otpBytes[8*k +: 8] : 8'h00;
    n = serialNum;
    return {OP_HMAC, m, s[7:0], s[15:8], o, n[71:64],
            {32{m[6]}} & {n[39:32], n[47:40], n[55:48], n[63:56]}, n[7:0], n[15:8],
            {16{m[6]}} & {n[23:16], n[31:24]}};
  endfunction : tail
  function automatic logic [15:0] crc(input logic s, input int n);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'h0000;
    for (int i = 0; i < n; i++) begin
      b = u_far.zb(s, i[7:0]);
      for (int j = 0; j < 8; j++) c = {c[14:0], 1'b0} ^ ((b[j] ^ c[15]) ? CRC_POLY : 16'h0);
    end
    return c;
  endfunction : crc
  // Entry: load, pass-through, opcode, mode, expected status word.
  task automatic cmd(input logic [33:0] t);
    logic [15:0]  sel;
    logic [255:0] sc, key, d;
    logic [512:0] b[5];
    sel = 16'($urandom());
    sc = {8{$urandom()}};
    key = {32{sel[3:0], 4'hc}};
    blkQ.delete();
    if (t[33]) begin
      scratchLoadData <= sc;
      scratchPassThru <= t[32];
      scratchLoad <= 1'b1;
      @(posedge clk);
      scratchLoad <= 1'b0;
    end
    wr(REG_CMD, {sel, t[23:16], t[31:24]});
    do @(negedge clk); while (busy !== 1'b0);
    rd(REG_STAT, {AXI_OKAY, 16'h0, t[15:0]});
    if (t[15:8] == STS_OK && t[31:24] == OP_HMAC) begin
      b[0] = {1'b1, key ^ {32{IPAD}}, {32{IPAD}}};
      b[1] = {1'b0, 256'h0, sc};
      b[2] = {1'b0, tail(t[23:16], sel), PAD_BYTE, 248'h0, INNER_LEN};
      b[3] = {1'b1, key ^ {32{OPAD}}, {32{OPAD}}};
      b[4] = {1'b0, dg(b[2]), PAD_BYTE, 184'h0, OUTER_LEN};
      d = dg(b[4]);
      for (int k = 0; k < 5; k++) chk("shaBlock", blkQ.pop_front(), b[k]);
      for (int k = 0; k < 8; k++) rd(REG_RESP + 6'(4*k), {AXI_OKAY, d[255-32*k -: 32]});
    end
  endtask : cmd
  task automatic lock(input logic [31:0] c, input logic [15:0] st, input logic [15:0] lk);
    wr(REG_CMD, c);
    do @(negedge clk); while (busy !== 1'b0);
    chk("lockBytes", {dataLockByte, configLockByte}, lk);
    rd(REG_STAT, {AXI_OKAY, 16'h0, st});
    rd(REG_LOCK, {AXI_OKAY, 16'h0, lk});
  endtask : lock
  logic [33:0] hm[13] = '{
    {2'b00, 16'h1100, 16'h0f02}, {2'b10, 16'h1101, 16'h0302}, {2'b10, 16'h1180, 16'h0302},
    {2'b10, 16'h1108, 16'h0302}, {2'b11, 16'h1100, 16'h0f0a}, {2'b10, 16'h3000, 16'h0302},
    {2'b10, 16'h1702, 16'h0302}, {2'b11, 16'h1144, 16'h000a}, {2'b10, 16'h1100, 16'h0002},
    {2'b10, 16'h1110, 16'h0002}, {2'b10, 16'h1120, 16'h0002}, {2'b10, 16'h1130, 16'h0002},
    {2'b10, 16'h1170, 16'h0002}};
  // Watchdog sized well above the whole sequence.
  initial begin
    #500000;
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(32'h0b15));
    otpBytes <= 88'({$urandom(), $urandom(), $urandom()});
    serialNum <= 72'({$urandom(), $urandom(), $urandom()});
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(REG_STAT, {AXI_OKAY, 32'h0});
    rd(REG_LOCK, {AXI_OKAY, 32'h5555});
    rd(6'h30, {AXI_SLVERR, 32'h0});
    rd(6'h06, {AXI_SLVERR, 32'h0});
    foreach (hm[i]) cmd(hm[i]);
    cc = crc(1'b0, CFG_BYTES);
    cd = crc(1'b1, 12);
    lock({cc ^ 16'h1, 8'h00, OP_LOCK}, 16'h0f02, 16'h5555);
    rd(REG_CRC, {AXI_OKAY, 16'h0, cc});
    lock({cc, 8'h00, OP_LOCK}, 16'h0002, 16'h55ff);
    lock({cc, 8'h00, OP_LOCK}, 16'h0f02, 16'h55ff);
    lock({cd, 8'h01, OP_LOCK}, 16'h0002, 16'hffff);
    rd(REG_CRC, {AXI_OKAY, 16'h0, cd});
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    lock({16'h0000, 8'h81, OP_LOCK}, 16'h0002, 16'hff55);
    close_out();
  end
endmodule : kdz_cmd_exec_bench
